// >>> common/sim_map.vh
/*
 * constants of the serial interface master: frame sizes, transfer
 * modes, framing codes, clock rates and fifo shape.
 * assumes inclusion by bare name from the design file.
 */
`ifndef SIM_MAP_VH
`define SIM_MAP_VH

`define SIM_DATA_W        16
`define SIM_FIFO_DEPTH    8
`define SIM_SEL_W         16
`define SIM_DIV_W         16
`define SIM_CNT_W         16
`define SIM_MIN_BITS      5'h04
`define SIM_MAX_BITS      5'h10
`define SIM_MODE_TXRX     2'h0
`define SIM_MODE_TXONLY   2'h1
`define SIM_MODE_RXONLY   2'h2
`define SIM_FMT_ALT       2'h1
`define SIM_CLK_MHZ       100
`define SIM_MAX_SCLK_MHZ  25
`define SIM_MIN_DIV       ((`SIM_CLK_MHZ + `SIM_MAX_SCLK_MHZ - 1) / `SIM_MAX_SCLK_MHZ)
// half of the smallest legal divider, sized for the half counter
`define SIM_MIN_HALF      16'h0002
`define SIM_ZERO16        16'h0000
`define SIM_ONES16        16'hffff

`endif

// >>> design/sim_master.v
/*
 * serial interface master: transmit and receive fifos, frame engine,
 * clock divider and sixteen active-low selects.
 * assumes a 100 MHz clock_i, synchronous active-low reset, and that
 * serial_data_in_i arrives asynchronously from the pin.
 */
// Summary of operation
// - spi framing unless frame format is 1 and alt framing enabled.
// - serial clock from divider value; never faster than 25 MHz.
// - frame size programmable from 4 to 16 bits.
// - each fifo word holds exactly frame-size bits.
// - transmit-receive mode: one received frame per transmitted frame.
// - transmit-only mode: send while data remains, drop input data.
// - receive-only starts on one dummy frame, receives frame count plus one frames.
// - serial output level is meaningless during receive-only.
// - select held across spi transfer; transmit transfer ends on empty fifo.
// - busy may lag; software waits for tx empty and not busy.
// - sixteen selects chosen by the slave select mask.
// - all selects active low.
// - data-port write pushes tx fifo, read pops rx fifo.
// - status shows tx empty, tx not full, rx full, rx not empty.
// - configuration accepted only while controller is disabled.
// - clock polarity and phase both configurable.
// - input sampled in the middle of each bit.
// - queued frames go out with a one-cycle gap in transmit-only, two cycles in transmit-receive.
`timescale 1ns/100ps
`include "sim_map.vh"

module sim_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clock_i,
  input  wire             rst_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [AW:0]      level_o
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_reg;
  reg [AW-1:0]    rd_reg;
  reg [AW:0]      level_reg;
  wire            push;
  wire            pop;

  assign in_ready_o  = (level_reg != DEPTH[AW:0]);
  assign out_valid_o = (level_reg != {(AW+1){1'b0}});
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_ready_i & out_valid_o;
  assign out_data_o  = mem_reg[rd_reg];
  assign level_o     = level_reg;

  always @(posedge clock_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_reg    <= {AW{1'b0}};
      rd_reg    <= {AW{1'b0}};
      level_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        level_reg <= level_reg + 1'b1;
      end else if (pop && !push) begin
        level_reg <= level_reg - 1'b1;
      end
    end
  end
endmodule

module sim_master (
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        controller_enable_i,
  input  wire [1:0]  transfer_mode_field_i,
  input  wire [3:0]  frame_width_field_i,
  input  wire [1:0]  frame_format_field_i,
  input  wire        alt_framing_enable_i,
  input  wire        clock_phase_i,
  input  wire        clock_polarity_i,
  input  wire [15:0] clock_divider_value_i,
  input  wire [15:0] receive_frame_count_i,
  input  wire [15:0] slave_select_mask_i,
  input  wire [15:0] tx_data_i,
  input  wire        tx_write_i,
  input  wire        rx_read_i,
  output wire [15:0] rx_data_o,
  output wire        tx_fifo_empty_o,
  output wire        tx_fifo_not_full_o,
  output wire        rx_fifo_full_o,
  output wire        rx_fifo_not_empty_o,
  output wire        busy_o,
  output wire        serial_clock_o,
  output wire        serial_data_out_o,
  input  wire        serial_data_in_i,
  output wire [15:0] select_n_o
);
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_LOAD  = 4'h2;
  localparam [3:0] ST_SHIFT = 4'h4;
  localparam [3:0] ST_GAP   = 4'h8;
  localparam [15:0] MIN_HALF = `SIM_MIN_HALF;

  reg [3:0]  state_reg;
  reg [1:0]  mode_reg;
  reg [4:0]  bits_reg;
  reg        alt_reg;
  reg        cpol_reg;
  reg        cpha_reg;
  reg [15:0] half_reg;
  reg [15:0] count_reg;
  reg [15:0] mask_reg;
  reg [15:0] frames_left_reg;
  reg [15:0] half_cnt_reg;
  reg        first_half_reg;
  reg [4:0]  bit_cnt_reg;
  reg [15:0] tx_sh_reg;
  reg [15:0] rx_sh_reg;
  reg        rx_push_reg;
  reg [15:0] rx_word_reg;
  reg        sdi_s1_reg;
  reg        sdi_s2_reg;

  wire        tx_valid;
  wire        tx_ready;
  wire [15:0] tx_head;
  wire        rx_ready;
  wire        rx_valid;
  wire [3:0]  rx_level;
  wire [15:0] width_mask;
  wire [4:0]  req_bits;
  wire [4:0]  last_bit;
  wire        pulse_bit;
  wire        rx_on;
  wire        rx_room;
  wire        half_end;
  wire        frame_end;
  wire        more_frames;
  wire        active;
  reg         tx_pop;

  // width field holds bits minus one; below four clamps up
  assign req_bits = ({1'b0, frame_width_field_i} < (`SIM_MIN_BITS - 5'h01))
                  ? `SIM_MIN_BITS : ({1'b0, frame_width_field_i} + 5'h01);
  assign width_mask = ~(`SIM_ONES16 << bits_reg);
  assign pulse_bit  = alt_reg && (bit_cnt_reg == 5'h00);
  assign last_bit   = bits_reg - {4'h0, ~alt_reg};
  assign rx_on      = (mode_reg != `SIM_MODE_TXONLY);
  // one push may still be in flight, so leave room for it
  assign rx_room    = !rx_on || (!rx_push_reg && rx_ready);
  assign half_end   = (half_cnt_reg == half_reg - 16'h0001);
  assign frame_end  = (state_reg == ST_SHIFT) && half_end &&
                      !first_half_reg && (bit_cnt_reg == last_bit);
  assign more_frames = (mode_reg == `SIM_MODE_RXONLY) ?
                       (frames_left_reg != `SIM_ZERO16) : tx_valid;
  assign active     = (state_reg == ST_LOAD) || (state_reg == ST_SHIFT);

  always @* begin
    tx_pop = 1'b0;
    if (controller_enable_i && (mode_reg != `SIM_MODE_RXONLY)) begin
      if (state_reg == ST_LOAD && tx_valid && rx_room) begin
        tx_pop = 1'b1;
      end
    end
    if (controller_enable_i && state_reg == ST_IDLE && tx_valid &&
        mode_reg == `SIM_MODE_RXONLY) begin
      tx_pop = 1'b1; // dummy frame only starts the transfer
    end
  end

  sim_fifo #(
    .WIDTH (`SIM_DATA_W),
    .DEPTH (`SIM_FIFO_DEPTH),
    .AW    (3)
  ) u_tx_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (tx_write_i),
    .in_ready_o  (tx_ready),
    .in_data_i   (tx_data_i & width_mask),
    .out_valid_o (tx_valid),
    .out_ready_i (tx_pop),
    .out_data_o  (tx_head),
    .level_o     ()
  );

  sim_fifo #(
    .WIDTH (`SIM_DATA_W),
    .DEPTH (`SIM_FIFO_DEPTH),
    .AW    (3)
  ) u_rx_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (rx_push_reg),
    .in_ready_o  (rx_ready),
    .in_data_i   (rx_word_reg),
    .out_valid_o (rx_valid),
    .out_ready_i (rx_read_i),
    .out_data_o  (rx_data_o),
    .level_o     (rx_level)
  );

  assign tx_fifo_empty_o     = !tx_valid;
  assign tx_fifo_not_full_o  = tx_ready;
  assign rx_fifo_full_o      = !rx_ready;
  assign rx_fifo_not_empty_o = rx_valid;
  assign busy_o              = (state_reg != ST_IDLE);

  // phase 0 leads with idle level, phase 1 with active level
  assign serial_clock_o = (state_reg == ST_SHIFT) ?
         (cpol_reg ^ (cpha_reg ? first_half_reg : !first_half_reg)) :
         cpol_reg;
  // receive-only leaves the output as whatever the shifter holds
  assign serial_data_out_o = tx_sh_reg[15] & !pulse_bit;
  // alt framing pulses the select for one bit ahead of each frame
  assign select_n_o = ~(mask_reg & {`SIM_SEL_W{active &&
                       (!alt_reg || (pulse_bit && state_reg == ST_SHIFT))}});

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      sdi_s1_reg <= 1'b0;
      sdi_s2_reg <= 1'b0;
    end else begin
      sdi_s1_reg <= serial_data_in_i;
      sdi_s2_reg <= sdi_s1_reg;
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode_reg  <= `SIM_MODE_TXRX;
      bits_reg  <= `SIM_MIN_BITS;
      alt_reg   <= 1'b0;
      cpol_reg  <= 1'b0;
      cpha_reg  <= 1'b0;
      half_reg  <= MIN_HALF;
      count_reg <= `SIM_ZERO16;
      mask_reg  <= `SIM_ZERO16;
    end else if (!controller_enable_i) begin
      mode_reg  <= transfer_mode_field_i;
      bits_reg  <= req_bits;
      alt_reg   <= (frame_format_field_i == `SIM_FMT_ALT) &&
                   alt_framing_enable_i;
      cpol_reg  <= clock_polarity_i;
      cpha_reg  <= clock_phase_i;
      // odd divider rounds down; clamp keeps the rate legal
      half_reg  <= ((clock_divider_value_i >> 1) < MIN_HALF) ?
                   MIN_HALF : (clock_divider_value_i >> 1);
      count_reg <= receive_frame_count_i;
      mask_reg  <= slave_select_mask_i;
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_reg       <= ST_IDLE;
      frames_left_reg <= `SIM_ZERO16;
      half_cnt_reg    <= `SIM_ZERO16;
      first_half_reg  <= 1'b1;
      bit_cnt_reg     <= 5'h00;
      tx_sh_reg       <= `SIM_ZERO16;
      rx_sh_reg       <= `SIM_ZERO16;
      rx_push_reg     <= 1'b0;
      rx_word_reg     <= `SIM_ZERO16;
    end else begin
      rx_push_reg <= 1'b0;
      if (!controller_enable_i) begin
        state_reg <= ST_IDLE;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            half_cnt_reg   <= `SIM_ZERO16;
            first_half_reg <= 1'b1;
            if (tx_valid) begin
              frames_left_reg <= count_reg + 16'h0001;
              state_reg       <= ST_LOAD;
            end
          end
          ST_LOAD: begin
            if (mode_reg == `SIM_MODE_RXONLY) begin
              if (rx_room) begin
                frames_left_reg <= frames_left_reg - 16'h0001;
                bit_cnt_reg     <= 5'h00;
                state_reg       <= ST_SHIFT;
              end
            end else if (tx_pop) begin
              tx_sh_reg   <= tx_head << (`SIM_MAX_BITS - bits_reg);
              bit_cnt_reg <= 5'h00;
              state_reg   <= ST_SHIFT;
            end else if (!tx_valid) begin
              state_reg <= ST_GAP;
            end
          end
          ST_SHIFT: begin
            if (half_end) begin
              half_cnt_reg <= `SIM_ZERO16;
              if (first_half_reg) begin
                first_half_reg <= 1'b0;
                if (!pulse_bit) begin
                  rx_sh_reg <= {rx_sh_reg[14:0], sdi_s2_reg};
                end
              end else begin
                first_half_reg <= 1'b1;
                if (frame_end) begin
                  rx_push_reg <= rx_on;
                  rx_word_reg <= rx_sh_reg & width_mask;
                  bit_cnt_reg <= 5'h00;
                  if (!more_frames) begin
                    state_reg <= ST_GAP;
                  end else if (mode_reg == `SIM_MODE_RXONLY) begin
                    state_reg <= ST_LOAD;
                  end else if (rx_on && rx_level >=
                               (`SIM_FIFO_DEPTH - 1)) begin
                    state_reg <= ST_LOAD; // stall: no room for reply
                  end else begin
                    state_reg <= ST_LOAD; // pop happens next cycle in transmit-only, one cycle later in transmit-receive
                  end
                end else begin
                  bit_cnt_reg <= bit_cnt_reg + 5'h01;
                  if (!pulse_bit) begin
                    tx_sh_reg <= {tx_sh_reg[14:0], 1'b0};
                  end
                end
              end
            end else begin
              half_cnt_reg <= half_cnt_reg + 16'h0001;
            end
          end
          ST_GAP: begin
            // one full clock period with every select released
            if (half_end && !first_half_reg) begin
              first_half_reg <= 1'b1;
              half_cnt_reg   <= `SIM_ZERO16;
              state_reg      <= ST_IDLE;
            end else if (half_end) begin
              first_half_reg <= 1'b0;
              half_cnt_reg   <= `SIM_ZERO16;
            end else begin
              half_cnt_reg <= half_cnt_reg + 16'h0001;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// >>> dv/sim_master_props.sv
/* checker of the serial interface master port behaviour.
   assumes binding onto sim_master, single clock domain. */
`timescale 1ns/100ps
module sim_master_props (
  input wire        clock_i,
  input wire        rst_n_i,
  input wire        controller_enable_i,
  input wire [1:0]  transfer_mode_field_i,
  input wire        alt_framing_enable_i,
  input wire        clock_polarity_i,
  input wire [15:0] slave_select_mask_i,
  input wire        tx_write_i,
  input wire        tx_fifo_empty_o,
  input wire        rx_fifo_not_empty_o,
  input wire        busy_o,
  input wire        serial_clock_o,
  input wire [15:0] select_n_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  idle_sel_high_a:
    assert property (!busy_o |-> select_n_o == 16'hffff)
    else $error("select low while idle");
  sel_in_mask_a:
    assert property ((~select_n_o & ~slave_select_mask_i) == 16'h0000)
    else $error("unmasked select driven");
  push_fills_a:
    assert property (tx_write_i && tx_fifo_empty_o |=> !tx_fifo_empty_o)
    else $error("push did not land");
  busy_start_a:
    assert property (controller_enable_i && !tx_fifo_empty_o && !busy_o
      |-> ##[1:3] (busy_o || !controller_enable_i))
    else $error("queued data not started");
  sel_hold_a:
    assert property ($rose(select_n_o[0]) && !alt_framing_enable_i &&
      controller_enable_i && $past(controller_enable_i)
      |-> $past(tx_fifo_empty_o))
    else $error("select released with data queued");
  clk_half_a:
    assert property ($changed(serial_clock_o) && controller_enable_i
      |=> $stable(serial_clock_o) || !controller_enable_i)
    else $error("serial clock half too short");
  txonly_drop_a:
    assert property (transfer_mode_field_i == 2'h1 &&
      $stable(transfer_mode_field_i) && !rx_fifo_not_empty_o
      |=> !rx_fifo_not_empty_o)
    else $error("receive data kept in transmit-only mode");
  idle_clk_a:
    assert property ((!controller_enable_i && $stable(clock_polarity_i))[*3]
      |-> serial_clock_o == clock_polarity_i)
    else $error("idle clock level wrong");
endmodule
bind sim_master sim_master_props PRP (.clock_i, .rst_n_i,
  .controller_enable_i, .transfer_mode_field_i, .alt_framing_enable_i,
  .clock_polarity_i, .slave_select_mask_i, .tx_write_i,
  .tx_fifo_empty_o, .rx_fifo_not_empty_o, .busy_o, .serial_clock_o,
  .select_n_o);

// >>> dv/sim_master_test.sv
/* self-checking bench of the serial interface master.
   assumes sim_master, the slave model and the bound checker. */
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sim_master_test;
  reg          clock_i = 0, rst_n_i = 0, en = 0, cpha = 0, cpol = 0;
  reg          wr = 0, rd = 0, hold = 0;
  reg   [1:0]  mode = 2'h0;
  reg   [3:0]  wf = 4'h7;
  reg   [15:0] cnt = 16'h0000, sel = 16'h0001, wd = 16'h0000, msk, ex;
  reg   [15:0] pat = 16'ha5c3;
  reg   [31:0] seed = 32'h0001_046a;
  reg   [15:0] div = 16'h0010;
  reg   [1:0]  fmt = 2'h1;
  reg          alt = 0;
  wire  [15:0] rdat, sel_n, got;
  wire         te, tnf, rf, rne, busy, sclk, mosi, miso;
  wire  [4:0]  bits = {1'b0, wf} + 5'h01;
  integer      n_fail = 0, n_checks = 0, cyc = 0, i, k, n_lo = 0, n_hi = 0;
  logic [15:0] q[$];
  always #5 clock_i = ~clock_i;
  sim_master DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .controller_enable_i(en), .transfer_mode_field_i(mode),
    .frame_width_field_i(wf), .frame_format_field_i(fmt),
    .alt_framing_enable_i(alt), .clock_phase_i(cpha),
    .clock_polarity_i(cpol), .clock_divider_value_i(div),
    .receive_frame_count_i(cnt), .slave_select_mask_i(sel),
    .tx_data_i(wd), .tx_write_i(wr), .rx_read_i(rd), .rx_data_o(rdat),
    .tx_fifo_empty_o(te), .tx_fifo_not_full_o(tnf),
    .rx_fifo_full_o(rf), .rx_fifo_not_empty_o(rne), .busy_o(busy),
    .serial_clock_o(sclk), .serial_data_out_o(mosi),
    .serial_data_in_i(miso), .select_n_o(sel_n));
  sim_slave_model SLV (.sclk_i(sclk), .mosi_i(mosi), .cs_n_i(&sel_n),
    .cpol_i(cpol), .cpha_i(cpha), .bits_i(bits), .pat_i(pat),
    .miso_o(miso), .got_o(got));
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task complete_run;
    begin
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // fields change only while disabled
  // pins taken as already handed to this controller
  task cfg(input [1:0] m, input [3:0] w, input ph, input po, input e);
    begin
      @(negedge clock_i);
      en = 0;
      mode = m;
      wf = w;
      cpha = ph;
      cpol = po;
      repeat (4) @(negedge clock_i);
      en = e;
      msk = 16'hffff >> (15 - w);
    end
  endtask
  // words go back to back so the transfer never runs dry
  task push(input [15:0] d, input exp);
    begin
      wd = d;
      wr = 1;
      if (exp) q.push_back(pat & msk);
      @(negedge clock_i);
    end
  endtask
  task idle;
    begin
      wr = 0;
      repeat (4) @(negedge clock_i);
      while (!(te === 1 && busy === 0 && q.size() == 0)) @(negedge clock_i);
    end
  endtask
  // select-low and active-clock cycles, sampled where settled
  always @(negedge clock_i) begin
    if (sel_n !== 16'hffff) n_lo++;
    if (sclk !== cpol) n_hi++;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run;
    end
  end
  always @(negedge clock_i) begin
    if (rd) rd = 0;
    else if (rne === 1 && !hold) begin
      rd = 1;
      if (q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        ex = q.pop_front();
        `CHK(rdat, ex)
      end
    end
  end
  initial begin
    repeat (2) @(negedge clock_i);
    rst_n_i = 1;
    for (i = 0; i < 12; i++) begin
      sel = 16'h0001 << i;
      cfg(2'h0, (i % 3 == 0) ? 4'h3 : (i % 3 == 1) ? 4'h7 : 4'hf,
        i[0], i[1], 1);
      for (k = 0; k < 3; k++) begin
        seed = xs(seed);
        push(seed[15:0], 1);
      end
      idle;
      `CHK(got & msk, wd & msk)
      `CHK(sel_n, 16'hffff)
      $display("frames test %0d done", i);
    end
    cfg(2'h1, 4'h7, 0, 0, 1);
    push(16'h00c3, 0);
    push(16'h005a, 0);
    idle;
    `CHK(got & msk, 16'h005a)
    $display("transmit-only test done");
    cnt = 16'h0002;
    cfg(2'h2, 4'hb, 1, 0, 1);
    push(16'h0000, 0);
    for (k = 0; k < 3; k++) q.push_back(pat & msk);
    idle;
    $display("receive-only test done");
    // alt enable alone keeps spi; with format 1 one pulse bit per frame
    alt = 1;
    for (k = 0; k < 2; k++) begin
      fmt = k[1:0];
      cfg(2'h1, 4'h7, 0, 0, 1);
      n_lo = 0;
      push(16'h0011, 0);
      push(16'h0022, 0);
      idle;
      if (k == 1) `CHK(n_lo, 32)
      else begin
        `CHK(n_lo >= 256, 1'b1)
        `CHK(got & msk, 16'h0022)
      end
      $display("framing test %0d done", k);
    end
    // divider below the legal minimum: 4 system cycles per bit
    alt = 0;
    fmt = 2'h1;
    div = 16'h0002;
    cfg(2'h1, 4'h7, 0, 0, 1);
    n_hi = 0;
    push(16'h0069, 0);
    idle;
    `CHK(n_hi, 16)
    `CHK(got & msk, 16'h0069)
    div = 16'h0010;
    $display("clock rate test done");
    hold = 1;
    cfg(2'h0, 4'hf, 0, 1, 0);
    for (k = 0; k < 9; k++) push(16'h1234 + k[15:0], k < 8);
    wr = 0;
    `CHK(tnf, 1'b0)
    en = 1;
    while (!(te === 1 && busy === 0)) @(negedge clock_i);
    `CHK(rf, 1'b1)
    `CHK(got, 16'h123b)
    hold = 0;
    idle;
    `CHK(rne, 1'b0)
    $display("fifo fill test done");
    complete_run;
  end
endmodule

// >>> dv/sim_slave_model.sv
/* serial slave model: answers a fixed pattern msb first and records
   the data out bits. assumes master clock, data and any select. */
`timescale 1ns/100ps
module sim_slave_model (
  input  wire        sclk_i,
  input  wire        mosi_i,
  input  wire        cs_n_i,
  input  wire        cpol_i,
  input  wire        cpha_i,
  input  wire [4:0]  bits_i,
  input  wire [15:0] pat_i,
  output reg         miso_o,
  output reg  [15:0] got_o
);
  integer n;
  initial begin
    n = 0;
    miso_o = 1'b0;
    got_o = 16'h0000;
  end
  always @(negedge cs_n_i) n = 0;
  // a bit starts on entry to the first-half level
  always @(sclk_i) if (!cs_n_i) begin
    if ((sclk_i ^ cpol_i) == cpha_i) n = n + 1;
    else got_o = {got_o[14:0], mosi_i};
  end
  // released line toggles so a stale level is never sampled
  always @(n or cs_n_i) begin
    if (cs_n_i) miso_o = ~miso_o;
    else miso_o = pat_i[bits_i - 1 - (n + bits_i - cpha_i) % bits_i];
  end
endmodule
